// file: hw/bsf_unit.sv
// bit, shift, flag and core-control execution unit with wishbone access
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module bsf_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic op_valid_i,
	input wire bsf_pkg::bsf_op_t op_i,
	input wire logic [7:0] rd_val_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [4:0] io_addr_i,
	input wire logic [7:0] io_val_i,
	input wire logic mem_req_i,
	input wire logic mem_nvm_i,
	input wire logic nvm_busy_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [7:0] rd_res_o,
	output logic rd_we_o,
	output logic io_we_o,
	output logic [4:0] io_addr_o,
	output logic [7:0] io_res_o,
	output logic [7:0] status_o,
	output logic sleep_o,
	output logic wdog_o,
	output logic brk_o,
	output logic done_o,
	output logic mem_stall_o
);
	import bsf_pkg::*;

	bsf_state_t s_q;
	bsf_state_t s_d;

	//--------------------------------------------------------------
	// next state
	//--------------------------------------------------------------
	always_comb begin
		logic [7:0] res;
		logic [7:0] fl;
		logic cout;
		logic shf;
		logic acc;
		res = rd_val_i;
		fl = s_q.status;
		cout = 1'b0;
		shf = 1'b0;
		acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
		s_d = s_q;
		s_d.rd_we = 1'b0;
		s_d.io_we = 1'b0;
		s_d.sleep = 1'b0;
		s_d.wdog = 1'b0;
		s_d.brk = 1'b0;
		s_d.done = 1'b0;

		// bus access; ack comes one edge after the strobe
		s_d.ack = acc;
		if (acc && !wb_we_i) begin
			case (wb_adr_i)
			OFS_STATUS: s_d.rdat = {24'h00_0000, s_q.status};
			OFS_RESULT: s_d.rdat = {24'h00_0000, s_q.rd_res};
			OFS_COUNT: s_d.rdat = {16'h0000, s_q.count};
			default: s_d.rdat = 32'h0000_0000;
			endcase
		end
		// a software write lands first so a same-cycle op still acts
		if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_STATUS) begin
			fl = wb_dat_i[7:0];
		end

		if (op_valid_i) begin
			s_d.done = 1'b1;
			s_d.count = s_q.count + 16'h0001;
			case (op_i)
			OP_SHIFT_L: begin
				res = {rd_val_i[6:0], 1'b0};
				cout = rd_val_i[7];
				fl[FLG_H] = rd_val_i[3];
				shf = 1'b1;
			end
			OP_SHIFT_R: begin
				res = {1'b0, rd_val_i[7:1]};
				cout = rd_val_i[0];
				shf = 1'b1;
			end
			OP_ROT_L: begin
				res = {rd_val_i[6:0], fl[FLG_C]};
				cout = rd_val_i[7];
				fl[FLG_H] = rd_val_i[3];
				shf = 1'b1;
			end
			OP_ROT_R: begin
				res = {fl[FLG_C], rd_val_i[7:1]};
				cout = rd_val_i[0];
				shf = 1'b1;
			end
			OP_SHIFT_RA: begin
				res = {rd_val_i[7], rd_val_i[7:1]};
				cout = rd_val_i[0];
				shf = 1'b1;
			end
			OP_SWAP: begin
				res = {rd_val_i[3:0], rd_val_i[7:4]};
				s_d.rd_we = 1'b1;
			end
			OP_IO_SET: begin
				s_d.io_res = io_val_i | (8'h01 << bit_sel_i);
				s_d.io_addr = io_addr_i;
				s_d.io_we = 1'b1;
			end
			OP_IO_CLR: begin
				s_d.io_res = io_val_i & ~(8'h01 << bit_sel_i);
				s_d.io_addr = io_addr_i;
				s_d.io_we = 1'b1;
			end
			OP_BIT_STORE: fl[FLG_T] = rd_val_i[bit_sel_i];
			OP_BIT_LOAD: begin
				res[bit_sel_i] = fl[FLG_T];
				s_d.rd_we = 1'b1;
			end
			// the named flag operations are these two with a fixed index
			OP_FLAG_SET: fl[bit_sel_i] = 1'b1;
			OP_FLAG_CLR: fl[bit_sel_i] = 1'b0;
			OP_SLEEP: s_d.sleep = 1'b1;
			OP_WDOG: s_d.wdog = 1'b1;
			OP_BRK: s_d.brk = 1'b1;
			default: ;
			endcase
			if (shf) begin
				fl[FLG_C] = cout;
				fl[FLG_Z] = (res == 8'h00);
				fl[FLG_N] = res[7];
				fl[FLG_V] = res[7] ^ cout;
				fl[FLG_S] = res[7] ^ (res[7] ^ cout);
				s_d.rd_we = 1'b1;
			end
			if (s_d.rd_we) begin
				s_d.rd_res = res;
			end
		end
		s_d.status = fl;

		// an nvm access holds the core one cycle, longer while it is busy
		s_d.nvm_stall = (mem_req_i & mem_nvm_i)
			| (s_q.nvm_stall & nvm_busy_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	assign rd_res_o = s_q.rd_res;
	assign rd_we_o = s_q.rd_we;
	assign io_we_o = s_q.io_we;
	assign io_addr_o = s_q.io_addr;
	assign io_res_o = s_q.io_res;
	assign status_o = s_q.status;
	assign sleep_o = s_q.sleep;
	assign wdog_o = s_q.wdog;
	assign brk_o = s_q.brk;
	assign done_o = s_q.done;
	assign mem_stall_o = s_q.nvm_stall;

	//--------------------------------------------------------------
	// checks
	//--------------------------------------------------------------
	logic h_vld_q;
	bsf_op_t h_op_q;
	logic [7:0] h_rd_q;
	logic [2:0] h_bit_q;
	logic [7:0] h_stat_q;
	logic [7:0] h_io_q;
	logic [4:0] h_ioa_q;
	logic h_bwr_q;
	logic h_flag_op;
	logic h_set;

	always_ff @(posedge clk_i) begin
		h_vld_q <= op_valid_i & ~rst_i;
		h_op_q <= op_i;
		h_rd_q <= rd_val_i;
		h_bit_q <= bit_sel_i;
		h_stat_q <= status_o;
		h_io_q <= io_val_i;
		h_ioa_q <= io_addr_i;
		h_bwr_q <= wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	end

	// named flag operations arrive as a raise or lower by index
	assign h_flag_op = h_vld_q && !h_bwr_q
		&& (h_op_q == OP_FLAG_SET || h_op_q == OP_FLAG_CLR);
	assign h_set = h_op_q == OP_FLAG_SET;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	//--------------------------------------------------------------
	// shift, rotate and nibble checks
	//--------------------------------------------------------------
	chk_shl_result: assert property (h_vld_q
		&& h_op_q == OP_SHIFT_L |-> rd_we_o
		&& rd_res_o == {h_rd_q[6:0], 1'b0} && status_o[FLG_C] == h_rd_q[7]
		&& status_o[FLG_H] == h_rd_q[3])
		else $error("shift left result or flags wrong");
	chk_shr_result: assert property (h_vld_q
		&& h_op_q == OP_SHIFT_R |-> rd_we_o
		&& rd_res_o == {1'b0, h_rd_q[7:1]}
		&& status_o[FLG_C] == h_rd_q[0])
		else $error("shift right result or carry wrong");
	chk_rotl_carry: assert property (h_vld_q
		&& h_op_q == OP_ROT_L && !h_bwr_q |->
		rd_res_o == {h_rd_q[6:0], h_stat_q[FLG_C]}
		&& status_o[FLG_C] == h_rd_q[7] && status_o[FLG_H] == h_rd_q[3])
		else $error("rotate left wrong");
	chk_rotr_carry: assert property (h_vld_q
		&& h_op_q == OP_ROT_R && !h_bwr_q |->
		rd_res_o == {h_stat_q[FLG_C], h_rd_q[7:1]}
		&& status_o[FLG_C] == h_rd_q[0])
		else $error("rotate right wrong");
	chk_sar_shift: assert property (h_vld_q
		&& h_op_q == OP_SHIFT_RA |-> rd_we_o
		&& rd_res_o[6:0] == h_rd_q[7:1]
		&& done_o)
		else $error("arithmetic shift moved bits wrong");
	chk_sar_sign: assert property (h_vld_q
		&& h_op_q == OP_SHIFT_RA |->
		rd_res_o[7] == h_rd_q[7]
		&& status_o[FLG_C] == h_rd_q[0])
		else $error("arithmetic shift lost sign or carry");
	chk_shift_zn: assert property (h_vld_q
		&& h_op_q inside {[OP_SHIFT_L:OP_SHIFT_RA]} |->
		status_o[FLG_Z] == (rd_res_o == 8'h00)
		&& status_o[FLG_N] == rd_res_o[7])
		else $error("shift zero or negative flag wrong");
	chk_swap_quiet: assert property (h_vld_q
		&& h_op_q == OP_SWAP && !h_bwr_q |-> rd_we_o
		&& rd_res_o == {h_rd_q[3:0], h_rd_q[7:4]}
		&& status_o == h_stat_q)
		else $error("nibble exchange wrong");

	//--------------------------------------------------------------
	// single bit checks
	//--------------------------------------------------------------
	chk_io_bit: assert property (h_vld_q
		&& h_op_q == OP_IO_SET |-> io_we_o && !rd_we_o
		&& io_res_o == (h_io_q | (8'h01 << h_bit_q))
		&& io_addr_o == h_ioa_q)
		else $error("io bit raise wrong");
	chk_io_clear: assert property (h_vld_q
		&& h_op_q == OP_IO_CLR |-> io_we_o && !rd_we_o
		&& io_res_o == (h_io_q & ~(8'h01 << h_bit_q))
		&& io_addr_o == h_ioa_q)
		else $error("io bit lower wrong");
	chk_io_flags: assert property (h_vld_q
		&& h_op_q inside {OP_IO_SET, OP_IO_CLR} && !h_bwr_q |->
		status_o == h_stat_q
		&& done_o)
		else $error("io bit operation changed a flag");
	chk_store_flag: assert property (h_vld_q
		&& h_op_q == OP_BIT_STORE && !h_bwr_q |->
		status_o == {h_stat_q[7], h_rd_q[h_bit_q], h_stat_q[5:0]}
		&& !rd_we_o)
		else $error("bit store to transfer flag wrong");
	chk_load_bit: assert property (h_vld_q
		&& h_op_q == OP_BIT_LOAD && !h_bwr_q |-> rd_we_o
		&& rd_res_o[h_bit_q] == h_stat_q[FLG_T]
		&& status_o == h_stat_q)
		else $error("bit load from transfer flag wrong");
	chk_load_others: assert property (h_vld_q
		&& h_op_q == OP_BIT_LOAD |->
		((rd_res_o ^ h_rd_q) & ~(8'h01 << h_bit_q)) == 8'h00
		&& done_o)
		else $error("bit load changed other bits");

	//--------------------------------------------------------------
	// status flag checks
	//--------------------------------------------------------------
	chk_raise_one: assert property (h_vld_q
		&& h_op_q == OP_FLAG_SET && !h_bwr_q |->
		status_o == (h_stat_q | (8'h01 << h_bit_q))
		&& !rd_we_o)
		else $error("status bit raise touched other bits");
	chk_lower_one: assert property (h_vld_q
		&& h_op_q == OP_FLAG_CLR && !h_bwr_q |->
		status_o == (h_stat_q & ~(8'h01 << h_bit_q))
		&& !rd_we_o)
		else $error("status bit lower touched other bits");
	chk_carry_flag: assert property (h_flag_op
		&& h_bit_q == FLG_C |-> status_o[FLG_C] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_C)) == 8'h00
		&& done_o)
		else $error("carry assert or drop wrong");
	chk_zero_flag: assert property (h_flag_op
		&& h_bit_q == FLG_Z |-> status_o[FLG_Z] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_Z)) == 8'h00
		&& done_o)
		else $error("zero flag assert or drop wrong");
	chk_neg_flag: assert property (h_flag_op
		&& h_bit_q == FLG_N |-> status_o[FLG_N] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_N)) == 8'h00
		&& done_o)
		else $error("negative flag assert or drop wrong");
	chk_sign_flag: assert property (h_flag_op
		&& h_bit_q == FLG_S |-> status_o[FLG_S] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_S)) == 8'h00
		&& done_o)
		else $error("sign flag assert or drop wrong");
	chk_ovf_flag: assert property (h_flag_op
		&& h_bit_q == FLG_V |-> status_o[FLG_V] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_V)) == 8'h00
		&& done_o)
		else $error("overflow flag assert or drop wrong");
	chk_xfer_flag: assert property (h_flag_op
		&& h_bit_q == FLG_T |-> status_o[FLG_T] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_T)) == 8'h00
		&& done_o)
		else $error("transfer flag raise or lower wrong");
	chk_half_flag: assert property (h_flag_op
		&& h_bit_q == FLG_H |-> status_o[FLG_H] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_H)) == 8'h00
		&& done_o)
		else $error("half-carry assert or drop wrong");
	chk_irq_flag: assert property (h_flag_op
		&& h_bit_q == FLG_I |-> status_o[FLG_I] == h_set
		&& ((status_o ^ h_stat_q) & ~(8'h01 << FLG_I)) == 8'h00
		&& done_o)
		else $error("interrupt enable allow or block wrong");

	//--------------------------------------------------------------
	// core control and memory timing checks
	//--------------------------------------------------------------
	chk_nop_quiet: assert property (h_vld_q
		&& h_op_q == OP_NOP && !h_bwr_q |->
		status_o == h_stat_q && !rd_we_o && !io_we_o
		&& done_o)
		else $error("no-operation changed state");
	chk_done_pulse: assert property (done_o
		== h_vld_q
		&& !(rd_we_o && !done_o)
		&& !(io_we_o && !done_o))
		else $error("operation did not finish in one cycle");
	chk_sleep_pulse: assert property (sleep_o
		== (h_vld_q && h_op_q == OP_SLEEP)
		&& wdog_o == (h_vld_q && h_op_q == OP_WDOG)
		&& !(sleep_o && wdog_o))
		else $error("sleep or watchdog pulse misplaced");
	chk_sleep_flags: assert property (h_vld_q
		&& h_op_q inside {OP_SLEEP, OP_WDOG} && !h_bwr_q |->
		status_o == h_stat_q
		&& !rd_we_o && !io_we_o)
		else $error("sleep or watchdog changed state");
	chk_break_pulse: assert property (brk_o
		== (h_vld_q && h_op_q == OP_BRK)
		&& !(brk_o && sleep_o)
		&& !(brk_o && wdog_o))
		else $error("break pulse misplaced");
	chk_break_flags: assert property (h_vld_q
		&& h_op_q == OP_BRK && !h_bwr_q |->
		status_o == h_stat_q
		&& !rd_we_o && !io_we_o)
		else $error("break changed state");
	chk_nvm_stall: assert property (mem_req_i
		&& mem_nvm_i |=>
		mem_stall_o
		&& !done_o)
		else $error("nvm access added no cycle");
	chk_nvm_hold: assert property (mem_stall_o
		&& nvm_busy_i |=>
		mem_stall_o
		&& !done_o)
		else $error("busy nvm controller released the stall");

endmodule

// file: hw/bsf_pkg.sv
// constants, types and state layout of the bit, shift and flag unit
//------------------------------------------------------------------
// Functional notes
// - shift left: zero in, bit7 to carry, one cycle
// - shift right: zero in top, bit0 to carry
// - rotate left through carry, one cycle
// - rotate right through carry, one cycle
// - arithmetic right: bits 7..1 move down
// - nibble exchange, flags untouched, one cycle
// - io bit raise/lower, flags untouched
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - status bit raise touches only that bit
// - status bit lower touches only that bit
// - zero flag assert/drop, only zero changes
// - negative assert/drop, only negative changes
// - sign and overflow assert/drop, alone
// - transfer flag raise/lower, alone
// - half-carry assert/drop, alone
// - global interrupt allow/block, alone
// - no-operation changes no flag or register except the op count, one cycle
// - sleep and watchdog restart signal out
// - break hands control to debug logic
// - nonvolatile accesses add at least one cycle
//------------------------------------------------------------------
package bsf_pkg;

	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_SHIFT_L = 4'h1,
		OP_SHIFT_R = 4'h2,
		OP_ROT_L = 4'h3,
		OP_ROT_R = 4'h4,
		OP_SHIFT_RA = 4'h5,
		OP_SWAP = 4'h6,
		OP_IO_SET = 4'h7,
		OP_IO_CLR = 4'h8,
		OP_BIT_STORE = 4'h9,
		OP_BIT_LOAD = 4'ha,
		OP_FLAG_SET = 4'hb,
		OP_FLAG_CLR = 4'hc,
		OP_SLEEP = 4'hd,
		OP_WDOG = 4'he,
		OP_BRK = 4'hf
	} bsf_op_t;

	// status byte bit positions
	localparam logic [2:0] FLG_C = 3'h0;
	localparam logic [2:0] FLG_Z = 3'h1;
	localparam logic [2:0] FLG_N = 3'h2;
	localparam logic [2:0] FLG_V = 3'h3;
	localparam logic [2:0] FLG_S = 3'h4;
	localparam logic [2:0] FLG_H = 3'h5;
	localparam logic [2:0] FLG_T = 3'h6;
	localparam logic [2:0] FLG_I = 3'h7;

	// register map, byte addresses
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_RESULT = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;

	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] rd_res;
		logic rd_we;
		logic io_we;
		logic [4:0] io_addr;
		logic [7:0] io_res;
		logic sleep;
		logic wdog;
		logic brk;
		logic done;
		logic nvm_stall;
		logic ack;
		logic [31:0] rdat;
		logic [15:0] count;
	} bsf_state_t;

	localparam bsf_state_t STATE_RST = '{
		status: STATUS_RST,
		rd_res: 8'h00,
		rd_we: 1'b0,
		io_we: 1'b0,
		io_addr: 5'h00,
		io_res: 8'h00,
		sleep: 1'b0,
		wdog: 1'b0,
		brk: 1'b0,
		done: 1'b0,
		nvm_stall: 1'b0,
		ack: 1'b0,
		rdat: 32'h0000_0000,
		count: COUNT_RST
	};

endpackage

// file: tb/bsf_core_model.sv
// far-side model: one general register and one io register with write-back
`timescale 1ns/1ps
module bsf_core_model (
	input wire logic clk_i,
	input wire logic load_i,
	input wire logic [7:0] load_reg_i,
	input wire logic [7:0] load_io_i,
	input wire logic rd_we_i,
	input wire logic [7:0] rd_res_i,
	input wire logic io_we_i,
	input wire logic [7:0] io_res_i,
	output logic [7:0] rd_val_o,
	output logic [7:0] io_val_o
);
	logic [7:0] reg_q;
	logic [7:0] io_q;
	// forward write-back, it lands a cycle after the op that made it
	assign rd_val_o = rd_we_i ? rd_res_i : reg_q;
	assign io_val_o = io_we_i ? io_res_i : io_q;
	always_ff @(posedge clk_i) begin
		if (load_i) begin
			reg_q <= load_reg_i;
			io_q <= load_io_i;
		end else begin
			if (rd_we_i) reg_q <= rd_res_i;
			if (io_we_i) io_q <= io_res_i;
		end
	end
endmodule

// file: tb/bsf_unit_bench.sv
// self-checking bench of the bit, shift and flag unit
`timescale 1ns/1ps
module bsf_unit_bench;
	import bsf_pkg::*;
	logic clk_i, rst_i, op_valid_i, mem_req_i, mem_nvm_i, nvm_busy_i;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rd_we_o, io_we_o;
	logic sleep_o, wdog_o, brk_o, done_o, mem_stall_o, load_i, e_we, e_iowe;
	bsf_op_t op_i;
	logic [7:0] rd_val_i, io_val_i, wb_adr_i, rd_res_o, io_res_o, status_o;
	logic [7:0] m_reg, m_io, m_sr, m_res, m_iores, ld_reg, ld_io;
	logic [2:0] bit_sel_i, e_pl;
	logic [4:0] io_addr_i, io_addr_o, ioa, m_ioa;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, d;
	int checked, n_mismatch, n_ops, cyc_n;
	bit pend;

	bsf_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i),
		.op_i(op_i), .rd_val_i(rd_val_i), .bit_sel_i(bit_sel_i),
		.io_addr_i(io_addr_i), .io_val_i(io_val_i), .mem_req_i(mem_req_i),
		.mem_nvm_i(mem_nvm_i), .nvm_busy_i(nvm_busy_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rd_res_o(rd_res_o), .rd_we_o(rd_we_o),
		.io_we_o(io_we_o), .io_addr_o(io_addr_o), .io_res_o(io_res_o),
		.status_o(status_o), .sleep_o(sleep_o), .wdog_o(wdog_o),
		.brk_o(brk_o),
		.done_o(done_o), .mem_stall_o(mem_stall_o));
	bsf_core_model u_core (.clk_i(clk_i), .load_i(load_i),
		.load_reg_i(ld_reg), .load_io_i(ld_io), .rd_we_i(rd_we_o),
		.rd_res_i(rd_res_o), .io_we_i(io_we_o), .io_res_i(io_res_o),
		.rd_val_o(rd_val_i), .io_val_o(io_val_i));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n > 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// expected effect of one op on the mirrored register, io and flags
	function automatic void model(bsf_op_t o, logic [2:0] b);
		logic [7:0] r;
		logic c;
		r = m_reg;
		c = m_sr[FLG_C];
		e_pl = 3'h0;
		e_iowe = 1'b0;
		case (o)
		OP_SHIFT_L: {c, r} = {m_reg, 1'b0};
		OP_SHIFT_R: {r, c} = {1'b0, m_reg};
		OP_ROT_L: {c, r} = {m_reg, m_sr[FLG_C]};
		OP_ROT_R: {r, c} = {m_sr[FLG_C], m_reg};
		OP_SHIFT_RA: {r, c} = {m_reg[7], m_reg};
		OP_SWAP: r = {m_reg[3:0], m_reg[7:4]};
		OP_IO_SET, OP_IO_CLR: begin
			m_iores = m_io;
			m_iores[b] = (o == OP_IO_SET);
			m_io = m_iores;
			m_ioa = ioa;
			e_iowe = 1'b1;
		end
		OP_BIT_STORE: m_sr[FLG_T] = m_reg[b];
		OP_BIT_LOAD: r[b] = m_sr[FLG_T];
		OP_FLAG_SET: m_sr[b] = 1'b1;
		OP_FLAG_CLR: m_sr[b] = 1'b0;
		OP_SLEEP: e_pl = 3'h4;
		OP_WDOG: e_pl = 3'h2;
		OP_BRK: e_pl = 3'h1;
		default: ;
		endcase
		if (o inside {[OP_SHIFT_L:OP_SHIFT_RA]}) begin
			if (o == OP_SHIFT_L || o == OP_ROT_L) m_sr[FLG_H] = m_reg[3];
			m_sr[FLG_C] = c;
			m_sr[FLG_Z] = (r == 8'h00);
			m_sr[FLG_N] = r[7];
			m_sr[FLG_V] = r[7] ^ c;
			m_sr[FLG_S] = m_sr[FLG_N] ^ m_sr[FLG_V];
		end
		e_we = (o inside {[OP_SHIFT_L:OP_SWAP], OP_BIT_LOAD});
		if (e_we) m_reg = r;
		if (e_we) m_res = r;
	endfunction
	task automatic verify();
		if (pend) begin
			chk(16'({rd_we_o, rd_res_o}), 16'({e_we, m_res}));
			chk(16'(status_o), 16'(m_sr));
			chk(16'({io_we_o, io_addr_o, io_res_o}),
				16'({e_iowe, m_ioa, m_iores}));
			chk(16'({sleep_o, wdog_o, brk_o, done_o}), 16'({e_pl, 1'b1}));
		end
		pend = 1'b0;
	endtask
	task automatic op(input bsf_op_t o, input logic [2:0] b);
		@(posedge clk_i);
		ioa = 5'($urandom);
		op_valid_i <= 1'b1;
		load_i <= 1'b0;
		op_i <= o;
		bit_sel_i <= b;
		io_addr_i <= ioa;
		#1 verify();
		model(o, b);
		pend = 1'b1;
		n_ops++;
	endtask
	task automatic load(input logic [7:0] r, input logic [7:0] v);
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		load_i <= 1'b1;
		ld_reg <= r;
		ld_io <= v;
		#1 verify();
		m_reg = r;
		m_io = v;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		// look at ack once it has settled; it stands up to the next edge
		do begin
			@(posedge clk_i);
			#1;
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		@(posedge clk_i);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic nvm(input logic v, input logic bz);
		@(posedge clk_i);
		mem_req_i <= 1'b1;
		mem_nvm_i <= v;
		nvm_busy_i <= bz;
		@(posedge clk_i);
		mem_req_i <= 1'b0;
		#1 chk(16'(mem_stall_o), 16'(v));
		@(posedge clk_i);
		nvm_busy_i <= 1'b0;
		#1 chk(16'(mem_stall_o), 16'(v & bz));
		@(posedge clk_i);
		#1 chk(16'(mem_stall_o), 16'h0000);
	endtask

	initial begin
		{rst_i, op_valid_i, load_i, mem_req_i, mem_nvm_i, nvm_busy_i} = 6'h21;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = 0;
		{op_i, bit_sel_i, io_addr_i, wb_dat_i, ld_reg, ld_io} = 0;
		{m_sr, m_res, m_iores, m_ioa, d} = 0;
		void'($urandom(32'h608576b3));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk(16'(status_o), 16'(STATUS_RST));
		load(8'h81, 8'h5a);
		op(OP_SHIFT_L, 3'h0);
		op(OP_ROT_L, 3'h0);
		op(OP_ROT_R, 3'h0);
		op(OP_SHIFT_RA, 3'h0);
		load(8'h80, 8'hff);
		op(OP_SHIFT_RA, 3'h7);
		op(OP_SHIFT_R, 3'h7);
		for (int b = 0; b < 8; b++) begin
			op(OP_FLAG_SET, 3'(b));
			op(OP_FLAG_CLR, 3'(b));
			op(OP_FLAG_SET, 3'(b));
		end
		for (int i = 0; i < 80; i++) begin
			load(8'($urandom), 8'($urandom));
			repeat (4) op(bsf_op_t'(4'($urandom)), 3'($urandom));
		end
		load(8'h00, 8'h00);
		d = $urandom;
		wb(1'b1, OFS_STATUS, 4'h1);
		m_sr = d[7:0];
		wb(1'b0, OFS_STATUS, 4'hf);
		chk(16'(q[7:0]), 16'(m_sr));
		d = ~d;
		wb(1'b1, OFS_STATUS, 4'he);
		wb(1'b1, OFS_RESULT, 4'hf);
		wb(1'b0, OFS_STATUS, 4'hf);
		chk(16'(q[7:0]), 16'(m_sr));
		wb(1'b0, OFS_RESULT, 4'hf);
		chk(16'(q[7:0]), 16'(m_res));
		wb(1'b0, OFS_COUNT, 4'hf);
		chk(q[15:0], 16'(n_ops));
		wb(1'b0, 8'h10, 4'hf);
		chk(q[15:0], 16'h0000);
		op(OP_NOP, 3'h0);
		load(8'h00, 8'h00);
		nvm(1'b1, 1'b1);
		nvm(1'b1, 1'b0);
		nvm(1'b0, 1'b1);
		tally_and_finish();
	end
endmodule
